/* design/efc_pkg.sv */
// Package of register map, field positions and reset values for the embedded-function bank
package efc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_HUB_SLAVE_CONFIG = 8'h32;
  localparam logic [7:0] OFS_HUB_WRITE_BYTE   = 8'h33;
  localparam logic [7:0] OFS_SIG_MOTION_THR   = 8'h34;
  localparam logic [7:0] OFS_STEP_WINDOW      = 8'h3A;
  localparam logic [7:0] OFS_MIRRORED_CTRL    = 8'h3F;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_HUB_SLAVE_CONFIG = 8'h00;
  localparam logic [7:0] RST_HUB_WRITE_BYTE   = 8'h00;
  localparam logic [7:0] RST_SIG_MOTION_THR   = 8'h06;
  localparam logic [7:0] RST_STEP_WINDOW      = 8'h00;
  localparam logic       RST_PAGE_ENABLE      = 1'b1;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_READ_COUNT_LSB = 0;
  localparam int POS_READ_COUNT_MSB = 2;
  localparam int POS_SLAVE_DIRECTION = 7;
  localparam int POS_MC_REBOOT      = 7;
  localparam int POS_MC_SOFT_RESET  = 6;
  localparam int POS_MC_RESERVED    = 5;
  localparam int POS_MC_PAGE_ENABLE = 4;
  localparam int POS_MC_FILTER_SEL  = 3;
  localparam int POS_MC_ADDR_INC    = 2;
  localparam int POS_MC_BUS_DISABLE = 1;
  localparam int POS_MC_WIRE_MODE   = 0;

  // Step window unit in microseconds per count
  localparam int STEP_WINDOW_UNIT_US = 1638400;

  // Copy of the main control bits
  typedef struct packed {
    logic reboot;
    logic soft_reset;
    logic filter_select;
    logic addr_inc;
    logic bus_disable;
    logic wire_mode;
  } efc_main_ctrl_type;

  // Settings handed to the pedometer and hub engines
  typedef struct packed {
    logic       page_enable;
    logic       first_slave_read;
    logic [2:0] hub_read_count;
    logic [7:0] hub_write_byte;
    logic [7:0] sig_motion_threshold;
    logic [7:0] step_window;
  } efc_settings_type;

  // Serial register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } efc_access_type;

endpackage : efc_pkg

/* design/efc_byte_reg.sv */
// One 8-bit configuration byte with soft reset, write strobe and clock enable
module efc_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       soft_clear,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  // Register update: soft reset returns to the default
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RESET_VALUE;
    end else if (clk_en) begin
      if (soft_clear) begin
        q <= RESET_VALUE;
      end else if (wr_en) begin
        q <= wdata;
      end
    end
  end

endmodule // efc_byte_reg

/* design/efc_config_bank.sv */
// Embedded-function configuration page with mirrored control register

module efc_config_bank (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire efc_pkg::efc_access_type    acc,
  input  wire logic                       acc_first,
  input  wire efc_pkg::efc_main_ctrl_type main_ctrl,
  input  wire logic                       page_set,
  input  wire logic                       reload_done,
  output efc_pkg::efc_settings_type       settings,
  output logic                      [7:0] rdata,
  output logic                            rvalid,
  output logic                            reload_req,
  output logic                      [7:0] cur_addr
);

  // ****************************************************************
  // Address tracking for multi-byte access
  // ****************************************************************
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic       acc_any;
  logic [7:0] eff_addr;

  assign acc_any  = acc.wr | acc.rd;
  assign eff_addr = acc_first ? acc.addr : addr_reg;
  // Advance after each byte when incrementing is on
  assign addr_next = main_ctrl.addr_inc ? eff_addr + 8'h01 : eff_addr;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_reg <= 8'h00;
    end else if (clk_en && acc_any) begin
      addr_reg <= addr_next;
    end
  end

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic page_en_reg;
  logic soft_clear;
  logic wr_slv;
  logic wr_wbyte;
  logic wr_thr;
  logic wr_win;
  logic wr_ctrl;
  logic page_wr;

  // Page accesses are only honoured while enabled
  assign page_wr  = acc.wr & page_en_reg;
  assign wr_slv   = page_wr & (eff_addr == efc_pkg::OFS_HUB_SLAVE_CONFIG);
  assign wr_wbyte = page_wr & (eff_addr == efc_pkg::OFS_HUB_WRITE_BYTE);
  assign wr_thr   = page_wr & (eff_addr == efc_pkg::OFS_SIG_MOTION_THR);
  assign wr_win   = page_wr & (eff_addr == efc_pkg::OFS_STEP_WINDOW);
  assign wr_ctrl  = page_wr & (eff_addr == efc_pkg::OFS_MIRRORED_CTRL);
  // Soft reset copy drives a return to defaults
  assign soft_clear = main_ctrl.soft_reset;

  // ****************************************************************
  // Configuration bytes
  // ****************************************************************
  logic [7:0] slv_q;
  logic [7:0] wbyte_q;
  logic [7:0] thr_q;
  logic [7:0] win_q;

  efc_byte_reg #(.RESET_VALUE(efc_pkg::RST_HUB_SLAVE_CONFIG)) u_slv (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .soft_clear (soft_clear),
    .wr_en      (wr_slv),
    .wdata      (acc.wdata),
    .q          (slv_q)
  );

  efc_byte_reg #(.RESET_VALUE(efc_pkg::RST_HUB_WRITE_BYTE)) u_wbyte (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .soft_clear (soft_clear),
    .wr_en      (wr_wbyte),
    .wdata      (acc.wdata),
    .q          (wbyte_q)
  );

  efc_byte_reg #(.RESET_VALUE(efc_pkg::RST_SIG_MOTION_THR)) u_thr (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .soft_clear (soft_clear),
    .wr_en      (wr_thr),
    .wdata      (acc.wdata),
    .q          (thr_q)
  );

  efc_byte_reg #(.RESET_VALUE(efc_pkg::RST_STEP_WINDOW)) u_win (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .soft_clear (soft_clear),
    .wr_en      (wr_win),
    .wdata      (acc.wdata),
    .q          (win_q)
  );

  // ****************************************************************
  // Page enable bit
  // ****************************************************************
  logic page_en_next;

  // Only the enable bit of the mirrored register is writable
  assign page_en_next = soft_clear ? efc_pkg::RST_PAGE_ENABLE
                      : wr_ctrl ? acc.wdata[efc_pkg::POS_MC_PAGE_ENABLE]
                      : page_set ? 1'b1 : page_en_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_en_reg <= efc_pkg::RST_PAGE_ENABLE;
    end else if (clk_en) begin
      page_en_reg <= page_en_next;
    end
  end

  // ****************************************************************
  // Reboot request
  // ****************************************************************
  logic reload_next;

  // Held until the flash reload reports completion
  assign reload_next = main_ctrl.reboot | (reload_req & ~reload_done);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_req <= 1'b0;
    end else if (clk_en) begin
      reload_req <= reload_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] mirror_val;
  logic [7:0] rdata_next;

  // Copies come straight from the main control register; reserved reads 0
  assign mirror_val = {main_ctrl.reboot, main_ctrl.soft_reset, 1'b0, page_en_reg,
                       main_ctrl.filter_select, main_ctrl.addr_inc,
                       main_ctrl.bus_disable, main_ctrl.wire_mode};

  assign rdata_next = !page_en_reg ? 8'h00
                    : (eff_addr == efc_pkg::OFS_HUB_SLAVE_CONFIG) ? slv_q
                    : (eff_addr == efc_pkg::OFS_HUB_WRITE_BYTE) ? wbyte_q
                    : (eff_addr == efc_pkg::OFS_SIG_MOTION_THR) ? thr_q
                    : (eff_addr == efc_pkg::OFS_STEP_WINDOW) ? win_q
                    : (eff_addr == efc_pkg::OFS_MIRRORED_CTRL) ? mirror_val
                    : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else if (clk_en) begin
      rdata  <= acc.rd ? rdata_next : rdata;
      rvalid <= acc.rd;
    end
  end

  // ****************************************************************
  // Settings to the engines
  // ****************************************************************
  efc_pkg::efc_settings_type settings_next;

  // Direction bit 1 means read
  assign settings_next.first_slave_read     = slv_q[efc_pkg::POS_SLAVE_DIRECTION];
  assign settings_next.hub_read_count       =
    slv_q[efc_pkg::POS_READ_COUNT_MSB:efc_pkg::POS_READ_COUNT_LSB];
  assign settings_next.hub_write_byte       = wbyte_q;
  assign settings_next.sig_motion_threshold = thr_q;
  assign settings_next.step_window          = win_q;
  assign settings_next.page_enable          = page_en_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      settings <= '0;
      cur_addr <= 8'h00;
    end else if (clk_en) begin
      settings <= settings_next;
      cur_addr <= addr_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_thr_write;
    clk_en && acc.wr && page_en_reg && eff_addr == efc_pkg::OFS_SIG_MOTION_THR
      && !soft_clear;
  endsequence

  closed_page_write_a: assert property (clk_en && acc.wr && !page_en_reg && !soft_clear &&
      eff_addr != efc_pkg::OFS_MIRRORED_CTRL |=> $stable(thr_q) && $stable(win_q))
    else $error("write landed while page closed");
  thr_write_a: assert property (s_thr_write |=> thr_q == $past(acc.wdata))
    else $error("threshold write lost");
  soft_reset_a: assert property (clk_en && soft_clear |=>
      thr_q == efc_pkg::RST_SIG_MOTION_THR && win_q == efc_pkg::RST_STEP_WINDOW
      && page_en_reg == efc_pkg::RST_PAGE_ENABLE)
    else $error("soft reset did not restore defaults");
  read_count_a: assert property (clk_en |=> settings.hub_read_count ==
      $past(slv_q[efc_pkg::POS_READ_COUNT_MSB:efc_pkg::POS_READ_COUNT_LSB]))
    else $error("read count field mismatch");
  direction_a: assert property (clk_en |=>
      settings.first_slave_read == $past(slv_q[efc_pkg::POS_SLAVE_DIRECTION]))
    else $error("direction bit mismatch");
  mirror_copy_a: assert property (clk_en && acc.rd && page_en_reg &&
      eff_addr == efc_pkg::OFS_MIRRORED_CTRL |=> rdata[7] == $past(main_ctrl.reboot)
      && rdata[0] == $past(main_ctrl.wire_mode) && rdata[5] == 1'b0)
    else $error("mirror copy wrong");
  page_close_a: assert property (clk_en && wr_ctrl && !soft_clear &&
      !acc.wdata[efc_pkg::POS_MC_PAGE_ENABLE] && !page_set |=> !page_en_reg)
    else $error("page did not close");
  addr_inc_a: assert property (clk_en && acc_any && main_ctrl.addr_inc |=>
      addr_reg == $past(eff_addr) + 8'h01)
    else $error("address did not advance");
  reboot_a: assert property (clk_en && main_ctrl.reboot |=> reload_req)
    else $error("reboot not requested");

endmodule // efc_config_bank

/* bench/efc_config_bank_test.sv */
// Self-checking testbench of the embedded-function configuration page
module efc_config_bank_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                       sys_clk;
  logic                       rst_b;
  logic                       clk_en;
  efc_pkg::efc_access_type    acc;
  logic                       acc_first;
  efc_pkg::efc_main_ctrl_type main_ctrl;
  logic                       page_set;
  logic                       reload_done;
  efc_pkg::efc_settings_type  settings;
  logic                 [7:0] rdata;
  logic                       rvalid;
  logic                       reload_req;
  logic                 [7:0] cur_addr;
  int                         num_errors = 0;
  int                         samples_checked = 0;
  int                         cycle_count = 0;

  efc_config_bank efc_config_bank_inst (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .clk_en      (clk_en),
    .acc         (acc),
    .acc_first   (acc_first),
    .main_ctrl   (main_ctrl),
    .page_set    (page_set),
    .reload_done (reload_done),
    .settings    (settings),
    .rdata       (rdata),
    .rvalid      (rvalid),
    .reload_req  (reload_req),
    .cur_addr    (cur_addr)
  );

  // ****************************************************************
  // Clock, timeout and common tasks
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Cuts a hang short well after the planned sequence
  always @(posedge sys_clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 3000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One or two bytes of a serial access; the strobe stays up across a burst
  task automatic access(input logic wr, input logic rd, input logic [7:0] addr,
                        input logic [7:0] d0, input logic two, input logic [7:0] d1);
    @(posedge sys_clk);
    #1;
    acc = '{wr: wr, rd: rd, addr: addr, wdata: d0};
    acc_first = 1'b1;
    @(posedge sys_clk);
    #1;
    if (two) begin
      acc_first = 1'b0;
      acc.wdata = d1;
      @(posedge sys_clk);
      #1;
    end
    acc.wr = 1'b0;
    acc.rd = 1'b0;
  endtask

  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    access(1'b1, 1'b0, addr, data, 1'b0, 8'h00);
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
    access(1'b0, 1'b1, addr, 8'h00, 1'b0, 8'h00);
    check("read valid", 8'h01, {7'h00, rvalid});
    check(what, exp, rdata);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_values();
    check("threshold setting", 8'h06, settings.sig_motion_threshold);
    check("page enable setting", 8'h01, {7'h00, settings.page_enable});
    read_check(8'h32, 8'h00, "hub config reset");
    read_check(8'h33, 8'h00, "write byte reset");
    read_check(8'h34, 8'h06, "threshold reset");
    read_check(8'h3A, 8'h00, "window reset");
    read_check(8'h3F, 8'h10, "mirror reset");
    read_check(8'h35, 8'h00, "unmapped read");
  endtask

  task automatic rw_fields();
    write(8'h32, 8'h85);
    @(posedge sys_clk);
    #1;
    check("read count", 8'h05, {5'h00, settings.hub_read_count});
    check("direction read", 8'h01, {7'h00, settings.first_slave_read});
    check("read valid idle", 8'h00, {7'h00, rvalid});
    write(8'h32, 8'h02);
    @(posedge sys_clk);
    #1;
    check("direction write", 8'h00, {7'h00, settings.first_slave_read});
    check("read count two", 8'h02, {5'h00, settings.hub_read_count});
    read_check(8'h32, 8'h02, "hub config");
    write(8'h33, 8'hA5);
    read_check(8'h33, 8'hA5, "write byte");
    check("write byte setting", 8'hA5, settings.hub_write_byte);
    write(8'h34, 8'hFF);
    read_check(8'h34, 8'hFF, "threshold full range");
    check("threshold setting", 8'hFF, settings.sig_motion_threshold);
    write(8'h3A, 8'h80);
    read_check(8'h3A, 8'h80, "window");
    check("window setting", 8'h80, settings.step_window);
  endtask

  task automatic mirror_copies();
    logic [5:0] pat [2] = '{6'b001111, 6'b100101};
    foreach (pat[i]) begin
      main_ctrl = pat[i];
      write(8'h3F, 8'hDF);
      read_check(8'h3F, {pat[i][5:4], 2'b01, pat[i][3:0]}, "mirror copy");
      check("reboot request", {7'h00, pat[i][5]}, {7'h00, reload_req});
      main_ctrl = '0;
      reload_done = 1'b1;
      @(posedge sys_clk);
      #1;
      reload_done = 1'b0;
      check("reload released", 8'h00, {7'h00, reload_req});
    end
    main_ctrl = '0;
  endtask

  task automatic addr_increment();
    main_ctrl.addr_inc = 1'b1;
    access(1'b1, 1'b0, 8'h33, 8'h11, 1'b1, 8'h22);
    @(posedge sys_clk);
    #1;
    check("current address", 8'h35, cur_addr);
    read_check(8'h33, 8'h11, "burst first");
    read_check(8'h34, 8'h22, "burst second");
    main_ctrl.addr_inc = 1'b0;
    access(1'b1, 1'b0, 8'h33, 8'h44, 1'b1, 8'h55);
    read_check(8'h33, 8'h55, "no increment");
    read_check(8'h34, 8'h22, "neighbour kept");
  endtask

  task automatic reboot_and_soft_reset();
    main_ctrl.reboot = 1'b1;
    @(posedge sys_clk);
    #1;
    main_ctrl.reboot = 1'b0;
    check("reload request", 8'h01, {7'h00, reload_req});
    repeat (3) @(posedge sys_clk);
    #1;
    check("reload held", 8'h01, {7'h00, reload_req});
    reload_done = 1'b1;
    @(posedge sys_clk);
    #1;
    reload_done = 1'b0;
    check("reload cleared", 8'h00, {7'h00, reload_req});
    main_ctrl.soft_reset = 1'b1;
    @(posedge sys_clk);
    #1;
    main_ctrl.soft_reset = 1'b0;
    read_check(8'h34, 8'h06, "threshold after soft reset");
    read_check(8'h33, 8'h00, "write byte after soft reset");
    read_check(8'h3A, 8'h00, "window after soft reset");
    read_check(8'h32, 8'h00, "hub config after soft reset");
  endtask

  task automatic page_close();
    write(8'h3F, 8'h00);
    @(posedge sys_clk);
    #1;
    check("page closed", 8'h00, {7'h00, settings.page_enable});
    read_check(8'h34, 8'h00, "closed read");
    write(8'h34, 8'h77);
    page_set = 1'b1;
    @(posedge sys_clk);
    #1;
    page_set = 1'b0;
    read_check(8'h34, 8'h06, "closed write ignored");
    read_check(8'h3F, 8'h10, "page reopened");
    clk_en = 1'b0;
    write(8'h34, 8'h33);
    clk_en = 1'b1;
    read_check(8'h34, 8'h06, "frozen write");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    acc = '0;
    acc_first = 1'b0;
    main_ctrl = '0;
    page_set = 1'b0;
    reload_done = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    @(posedge sys_clk);
    #1;
    reset_values();
    rw_fields();
    mirror_copies();
    addr_increment();
    reboot_and_soft_reset();
    page_close();
    give_verdict();
  end
endmodule // efc_config_bank_test
